// ### include/wdt_pkg.sv
// Shared constants for the dual watchdog reset unit
package wdt_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1000;

  // Hardware watchdog timeouts, nominal, in milliseconds
  localparam int unsigned HW_SHORT_MS = 2000;
  localparam int unsigned HW_LONG_MS = 8000;
  localparam int unsigned HW_TOL_MS = 200;
  localparam int unsigned HW_SHORT_CYCLES = HW_SHORT_MS * CLK_KHZ;
  localparam int unsigned HW_LONG_CYCLES = HW_LONG_MS * CLK_KHZ;

  // Peripheral watchdog timing
  localparam int unsigned SEC_CYCLES = CLK_HZ;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam int unsigned PW_MIN_MINUTES = 1;
  localparam int unsigned PW_MAX_MINUTES = 255;

  // Length of one reset request, in cycles
  localparam int unsigned RESET_PULSE_CYCLES = 64;

  // Register byte offsets
  localparam logic [7:0] OFF_HW_CTRL = 8'h00;
  localparam logic [7:0] OFF_PW_CFG = 8'h04;
  localparam logic [7:0] OFF_PW_KICK = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h14;

  // Kick port address of the original I/O map, kept for reference
  localparam logic [15:0] IO_KICK_ADDR = 16'h0201;

  // Field positions
  localparam int HW_KICK_BIT = 1;
  localparam int PW_TMO_LSB = 0;
  localparam int PW_TMO_W = 8;
  localparam int PW_RTC_EN_BIT = 8;
  localparam int PW_ARM_BIT = 9;
  localparam int ST_HW_EXP_BIT = 0;
  localparam int ST_PW_EXP_BIT = 1;
  localparam int STATE_HW_RUN_BIT = 0;
  localparam int STATE_PW_ARM_BIT = 1;
  localparam int STATE_PW_LEFT_LSB = 8;

  // Reset values
  localparam logic [31:0] HW_CTRL_RST = 32'h0000_0000;
  localparam logic [PW_TMO_W-1:0] PW_TMO_RST = 8'h01;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
endpackage

// ### sim/test_dual_watchdog_reset_unit.sv
// Self-checking bench for the dual watchdog reset unit
`timescale 1ns/100ps
module test_dual_watchdog_reset_unit;
  import wdt_pkg::*;
  localparam int HS = 20;
  localparam int HL = 80;
  localparam int SC = 4;
  localparam int PC = 8;
  // Request seen two edges after the timeout runs out
  localparam int LAT = 2;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd, v;
  logic pready, pslverr, tsel = 0, hwen = 1, pwen = 1, kick, rreq, irq, err;
  int n_errors = 0, samples_checked = 0, seed = 48294, cyc = 0, n_rst = 0, n;
  always #2.5 pclk = ~pclk;
  dual_watchdog_reset_unit #(.HW_SHORT_CYC(HS), .HW_LONG_CYC(HL),
    .SEC_CYC(SC), .PULSE_CYC(PC)) i_dual_watchdog_reset_unit (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timeout_select_jumper(tsel),
    .hw_watchdog_enable_jumper(hwen), .periph_watchdog_enable_jumper(pwen),
    .watchdog_kick_line(kick), .cpu_reset_req(rreq), .irq(irq));
  always @(posedge rreq)
    n_rst++;
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      $display("[FAIL] %0t got %h want %h", $time, g, e);
      n_errors++;
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // No local limit: only the bench timeout ends a hung wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Tolerance of two cycles around the scaled timeout plus report latency
  task automatic expire(input int t);
    int d, m;
    d = 0;
    m = 0;
    while (rreq !== 1'b1 && d < 2000)
    begin
      @(posedge pclk);
      d++;
    end
    chk(d >= t - 2 && d <= t + 2, 1);
    while (rreq === 1'b1 && m < 100)
    begin
      @(posedge pclk);
      m++;
    end
    chk(m, PC);
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 5; i++)
    begin
      bus(0, i * 4, 0);
      chk(rd, i == 1);
    end
    bus(1, 32'h0000_0018, 7);
    chk(err, 1);
    bus(0, 32'h0000_0006, 0);
    chk(err, 1);
    chk(rd, 0);
    repeat (100) @(posedge pclk);
    chk(n_rst, 0);
    bus(1, 16, 3);
    for (int s = 0; s < 2; s++)
    begin
      tsel <= s;
      n = s ? HL : HS;
      bus(1, 0, 2);
      @(posedge pclk);
      chk(kick, 1);
      bus(1, 0, 0);
      repeat (3)
      begin
        repeat (n / 2) @(posedge pclk);
        bus(1, 0, 2);
        bus(1, 0, 0);
      end
      chk(n_rst, s);
      bus(1, 0, $random(seed) | 2);
      // The write above used three edges of the timeout
      expire(n + LAT - 3);
      bus(0, 12, 0);
      chk(rd, 1);
      chk(irq, 1);
      bus(1, 16, 0);
      @(posedge pclk);
      chk(irq, 0);
      bus(0, 20, 0);
      chk(rd[0], 0);
      bus(1, 16, 3);
      bus(1, 12, 1);
      @(posedge pclk);
      chk(irq, 0);
      repeat (2 * n) @(posedge pclk);
      chk(n_rst, s + 1);
    end
    for (int i = 0; i < 6; i++)
    begin
      v = i < 2 ? i * 255 : $random(seed) & 255;
      bus(1, 4, v);
      bus(0, 4, 0);
      chk(rd[7:0], v == 0 ? 1 : v);
    end
    bus(1, 4, 32'h0000_0201);
    repeat (300) @(posedge pclk);
    chk(n_rst, 2);
    bus(0, 20, 0);
    chk(rd[1], 1);
    bus(1, 4, 32'h0000_0301);
    repeat (3)
    begin
      repeat (200) @(posedge pclk);
      bus(0, 8, 0);
    end
    chk(n_rst, 2);
    expire(60 * SC + LAT);
    bus(0, 20, 0);
    chk(rd[1], 0);
    pwen <= 0;
    bus(1, 4, 32'h0000_0301);
    repeat (300) @(posedge pclk);
    chk(n_rst, 3);
    // Clock enable low freezes a running count past its timeout
    bus(1, 0, 2);
    bus(1, 0, 0);
    bus(1, 0, 2);
    ce <= 0;
    repeat (4 * HL) @(posedge pclk);
    chk(n_rst, 3);
    ce <= 1;
    repeat (4) @(posedge pclk);
    // Reset in mid-count stops the watchdog and drops the line
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    bus(0, OFF_STATE, 0);
    chk(rd, 0);
    chk(kick, 0);
    chk(irq, 0);
    repeat (4 * HL) @(posedge pclk);
    chk(n_rst, 3);
    hwen <= 0;
    bus(1, 0, 2);
    bus(1, 0, 0);
    repeat (300) @(posedge pclk);
    chk(n_rst, 3);
    print_verdict;
  end
endmodule

// ### sim/wdt_unit_monitor.sv
// Concurrent checks on the watchdog unit ports
`timescale 1ns/100ps
module wdt_unit_monitor #(
  parameter int unsigned HW_SHORT_CYC = 20,
  parameter int unsigned PULSE_CYC = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hw_watchdog_enable_jumper,
  input wire logic periph_watchdog_enable_jumper,
  input wire logic watchdog_kick_line,
  input wire logic cpu_reset_req
);
  logic wr0;
  int unsigned hi_q;
  int unsigned up_q;
  int unsigned off_q;
  assign wr0 = pready && pwrite && paddr == 32'h0000_0000;
  // up_q and off_q saturate so a long run never wraps them; hi_q clears whenever the request is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_q <= 0;
      up_q <= 0;
      off_q <= 0;
    end
    else
    begin
      hi_q <= cpu_reset_req ? hi_q + 1 : 0;
      if (up_q <= HW_SHORT_CYC)
        up_q <= up_q + 1;
      if (hw_watchdog_enable_jumper || periph_watchdog_enable_jumper)
        off_q <= 0;
      else if (off_q < 9)
        off_q <= off_q + 1;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  pready_comb_a: assert property (pready == (psel && penable && ce))
    else $error("pready not set by the access phase");
  bad_addr_a: assert property (pready && paddr[1:0] != 2'h0
    |-> pslverr && prdata == 32'h0000_0000)
    else $error("unaligned access not refused");
  kick_line_a:
    assert property (wr0 |=> watchdog_kick_line == $past(pwdata[1]))
    else $error("kick line does not follow control bit");
  kick_hold_a:
    assert property ($changed(watchdog_kick_line) |-> $past(wr0))
    else $error("kick line moved without a write");
  pulse_len_a:
    assert property ($fell(cpu_reset_req) |-> hi_q == PULSE_CYC)
    else $error("reset request of wrong length");
  no_early_a:
    assert property ($rose(cpu_reset_req) |-> up_q > HW_SHORT_CYC)
    else $error("reset request too soon after reset");
  jumpers_off_a:
    assert property (off_q > 5 |-> !$rose(cpu_reset_req))
    else $error("reset request with both watchdogs disabled");
  kick_read_a:
    assert property (pready && !pwrite && paddr == 32'h0000_0008
      |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("kick port read not clean");
endmodule

bind dual_watchdog_reset_unit wdt_unit_monitor #(
  .HW_SHORT_CYC(HW_SHORT_CYC), .PULSE_CYC(PULSE_CYC)) i_wdt_unit_monitor (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .hw_watchdog_enable_jumper(hw_watchdog_enable_jumper),
  .periph_watchdog_enable_jumper(periph_watchdog_enable_jumper),
  .watchdog_kick_line(watchdog_kick_line), .cpu_reset_req(cpu_reset_req));

// ### src/dual_watchdog_reset_unit.sv
// Two independent watchdogs with APB registers and reset request
//
// How it works
// - Two watchdogs run apart and either expiry raises cpu_reset_req.
// - The hardware timeout is 2 s or 8 s as the select jumper sets it.
// - After reset the hardware watchdog is stopped and does not count.
// - Each later one-then-zero pulse restarts it, else the board resets.
// - Once started, nothing software does can stop it.
// - The control bit is driven out on watchdog_kick_line.
// - With its enable jumper removed the hardware watchdog never fires.
// - The peripheral timeout is 1 to 255 whole minutes.
// - It counts only while its clock-module enable bit is set.
// - A read of the kick register restarts the peripheral timeout.
// - Peripheral expiry without a kick raises a reset request.
// - Its own jumper removed disables the peripheral watchdog alone.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module dual_watchdog_reset_unit
  import wdt_pkg::*;
#(
  parameter int unsigned HW_SHORT_CYC = wdt_pkg::HW_SHORT_CYCLES,
  parameter int unsigned HW_LONG_CYC = wdt_pkg::HW_LONG_CYCLES,
  parameter int unsigned SEC_CYC = wdt_pkg::SEC_CYCLES,
  parameter int unsigned PULSE_CYC = wdt_pkg::RESET_PULSE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timeout_select_jumper,
  input wire logic hw_watchdog_enable_jumper,
  input wire logic periph_watchdog_enable_jumper,
  output logic watchdog_kick_line,
  output logic cpu_reset_req,
  output logic irq
);
  import wdt_pkg::*;

  localparam int HW_W = 32;

  // Jumper synchronisers
  logic [2:0] jmp_meta_q;
  logic [2:0] jmp_q;
  logic sel_long;
  logic hw_jmp_en;
  logic pw_jmp_en;

  // Bus decode
  logic setup_ph;
  logic access_ph;
  logic wr_done;
  logic rd_done;
  logic [7:0] off;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;
  logic slverr_q;

  // Registers
  logic kick_bit_q;
  logic [PW_TMO_W-1:0] pw_tmo_q;
  logic pw_rtc_en_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;

  // Hardware watchdog
  logic hw_kick;
  logic hw_run_q;
  logic [HW_W-1:0] hw_cnt_q;
  logic hw_expire;

  // Peripheral watchdog
  logic pw_arm_q;
  logic pw_kick;
  logic pw_arm_wr;
  logic pw_count_en;
  logic sec_tick;
  logic min_tick;
  logic [PW_TMO_W-1:0] pw_left_q;
  logic pw_expire;

  // Reset generation
  logic hw_rst_act;
  logic pw_rst_act;
  logic rst_req_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      jmp_meta_q <= 3'h0;
      jmp_q <= 3'h0;
    end
    else if (ce)
    begin
      jmp_meta_q <= {periph_watchdog_enable_jumper,
                     hw_watchdog_enable_jumper, timeout_select_jumper};
      jmp_q <= jmp_meta_q;
    end
  end

  assign sel_long = jmp_q[0];
  assign hw_jmp_en = jmp_q[1];
  assign pw_jmp_en = jmp_q[2];

  // APB slave: zero wait states, data latched in the setup cycle
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable && ce;
  assign off = paddr[7:0];
  assign mapped = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'b00)
    && (off == OFF_HW_CTRL || off == OFF_PW_CFG || off == OFF_PW_KICK
    || off == OFF_STATUS || off == OFF_MASK || off == OFF_STATE);
  assign wr_done = access_ph && pwrite && !slverr_q;
  assign rd_done = access_ph && !pwrite && !slverr_q;
  assign pready = access_ph;
  assign pslverr = access_ph && slverr_q;
  assign prdata = prdata_q;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (off)
      OFF_HW_CTRL:
        rd_mux[HW_KICK_BIT] = kick_bit_q;
      OFF_PW_CFG:
      begin
        rd_mux[PW_TMO_LSB +: PW_TMO_W] = pw_tmo_q;
        rd_mux[PW_RTC_EN_BIT] = pw_rtc_en_q;
        rd_mux[PW_ARM_BIT] = pw_arm_q;
      end
      OFF_STATUS:
        rd_mux[1:0] = status_q;
      OFF_MASK:
        rd_mux[1:0] = mask_q;
      OFF_STATE:
      begin
        rd_mux[STATE_HW_RUN_BIT] = hw_run_q;
        rd_mux[STATE_PW_ARM_BIT] = pw_arm_q;
        rd_mux[STATE_PW_LEFT_LSB +: PW_TMO_W] = pw_left_q;
      end
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end
    else if (ce && setup_ph)
    begin
      prdata_q <= mapped ? rd_mux : 32'h0000_0000;
      slverr_q <= !mapped;
    end
  end

  // Hardware watchdog control bit; drives the external timer line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      kick_bit_q <= HW_CTRL_RST[HW_KICK_BIT];
    else if (ce && wr_done && off == OFF_HW_CTRL)
      kick_bit_q <= pwdata[HW_KICK_BIT];
  end

  assign watchdog_kick_line = kick_bit_q;

  // A kick is the clearing write that follows a set
  assign hw_kick = wr_done && off == OFF_HW_CTRL && kick_bit_q
    && !pwdata[HW_KICK_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hw_run_q <= 1'b0;
      hw_cnt_q <= '0;
    end
    else if (ce)
    begin
      if (!hw_jmp_en)
      begin
        hw_run_q <= 1'b0;
        hw_cnt_q <= '0;
      end
      else if (hw_expire)
      begin
        hw_run_q <= 1'b0;
        hw_cnt_q <= '0;
      end
      else if (hw_kick)
      begin
        // No write path clears hw_run_q
        hw_run_q <= 1'b1;
        hw_cnt_q <= sel_long ? HW_W'(HW_LONG_CYC - 1)
                             : HW_W'(HW_SHORT_CYC - 1);
      end
      else if (hw_run_q)
        hw_cnt_q <= hw_cnt_q - 1'b1;
    end
  end

  assign hw_expire = hw_run_q && hw_cnt_q == '0 && !hw_kick;

  // Peripheral watchdog configuration
  assign pw_arm_wr = wr_done && off == OFF_PW_CFG && pwdata[PW_ARM_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pw_tmo_q <= PW_TMO_RST;
      pw_rtc_en_q <= 1'b0;
    end
    else if (ce && wr_done && off == OFF_PW_CFG)
    begin
      // Zero is outside the legal range and is raised to the minimum
      if (pwdata[PW_TMO_LSB +: PW_TMO_W] == '0)
        pw_tmo_q <= PW_TMO_W'(PW_MIN_MINUTES);
      else
        pw_tmo_q <= pwdata[PW_TMO_LSB +: PW_TMO_W];
      pw_rtc_en_q <= pwdata[PW_RTC_EN_BIT];
    end
  end

  assign pw_kick = rd_done && off == OFF_PW_KICK;
  assign pw_count_en = pw_arm_q && pw_rtc_en_q && pw_jmp_en;

  wdt_tick_div #(
    .DIV(SEC_CYC)
  ) u_sec_div (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .clr(pw_kick || pw_arm_wr || !pw_arm_q),
    .en(pw_count_en),
    .tick(sec_tick)
  );

  wdt_tick_div #(
    .DIV(SEC_PER_MIN)
  ) u_min_div (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .clr(pw_kick || pw_arm_wr || !pw_arm_q),
    .en(sec_tick),
    .tick(min_tick)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pw_arm_q <= 1'b0;
      pw_left_q <= '0;
    end
    else if (ce)
    begin
      if (!pw_jmp_en)
      begin
        pw_arm_q <= 1'b0;
        pw_left_q <= '0;
      end
      else if (pw_expire)
      begin
        pw_arm_q <= 1'b0;
        pw_left_q <= '0;
      end
      else if (pw_arm_wr)
      begin
        pw_arm_q <= 1'b1;
        pw_left_q <= (pwdata[PW_TMO_LSB +: PW_TMO_W] == '0)
          ? PW_TMO_W'(PW_MIN_MINUTES) : pwdata[PW_TMO_LSB +: PW_TMO_W];
      end
      else if (pw_kick && pw_arm_q)
        pw_left_q <= pw_tmo_q;
      else if (min_tick && pw_left_q != '0)
        pw_left_q <= pw_left_q - 1'b1;
    end
  end

  assign pw_expire = pw_arm_q && min_tick && pw_left_q == PW_TMO_W'(1)
    && !pw_kick;

  // One fixed pulse for each watchdog
  wdt_reset_stretch #(
    .LEN(PULSE_CYC)
  ) u_hw_pulse (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .trig(hw_expire),
    .active(hw_rst_act)
  );

  wdt_reset_stretch #(
    .LEN(PULSE_CYC)
  ) u_pw_pulse (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .trig(pw_expire),
    .active(pw_rst_act)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_req_q <= 1'b0;
    else if (ce)
      rst_req_q <= hw_rst_act || pw_rst_act;
  end

  assign cpu_reset_req = rst_req_q;

  // Sticky expiry flags; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= STATUS_RST;
      mask_q <= MASK_RST;
    end
    else if (ce)
    begin
      status_q[ST_HW_EXP_BIT] <= hw_expire || (status_q[ST_HW_EXP_BIT]
        && !(wr_done && off == OFF_STATUS && pwdata[ST_HW_EXP_BIT]));
      status_q[ST_PW_EXP_BIT] <= pw_expire || (status_q[ST_PW_EXP_BIT]
        && !(wr_done && off == OFF_STATUS && pwdata[ST_PW_EXP_BIT]));
      if (wr_done && off == OFF_MASK)
        mask_q <= pwdata[1:0];
    end
  end

  assign irq = |(status_q & mask_q);
endmodule

// ### src/wdt_reset_stretch.sv
// Stretches a trigger pulse into a fixed-length reset request
`timescale 1ns/100ps
module wdt_reset_stretch #(
  parameter int unsigned LEN = 64,
  parameter int W = $clog2(LEN + 1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic trig,
  output logic active
);
  logic [W-1:0] left_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      left_q <= '0;
    else if (ce)
    begin
      // A second trigger during a pulse does not extend it
      if (trig && left_q == '0)
        left_q <= W'(LEN);
      else if (left_q != '0)
        left_q <= left_q - 1'b1;
    end
  end

  assign active = (left_q != '0);
endmodule

// ### src/wdt_tick_div.sv
// Enabled tick divider with synchronous restart
`timescale 1ns/100ps
module wdt_tick_div #(
  parameter int unsigned DIV = 60,
  parameter int W = $clog2(DIV + 1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic en,
  output logic tick
);
  logic [W-1:0] cnt_q;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (ce)
    begin
      if (clr)
        cnt_q <= '0;
      else if (en)
        cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end

  assign tick = ce && en && !clr && (cnt_q == LAST);
endmodule
